/* File: src/smrs_top.sv */
// smrs_top: supply monitor reset sequencer with axi4-lite registers
// assumes: detector flags are synchronous levels; open-drain pins resolved outside
module smrs_top (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // supply detector flags
   input  wire logic        io_supply_good,         // 3.3 v in range
   input  wire logic        core_supply_good,       // 1.2 v at power-up
   input  wire logic        v1v8_low,               // 1.8 v below minimum
   input  wire logic        v1v8_high,              // 1.8 v above maximum
   input  wire logic        core_supply_warning,    // 1.2 v outside limits
   input  wire logic        reg_1v8_enable_n,       // regulator enable pin
   // reset requests, active low
   input  wire logic        interrupt_controller_reset_req,
   input  wire logic        wdog0_reset_n,
   input  wire logic        wdog1_reset_n,
   // open-drain reset pins
   input  wire logic        analog_domain_reset_n_i,
   output logic             analog_domain_reset_n_o,
   output logic             analog_domain_reset_n_oe,
   input  wire logic        digital_domain_reset_n_i,
   output logic             digital_domain_reset_n_o,
   output logic             digital_domain_reset_n_oe,
   // domain resets and pin control
   output logic             analog_logic_reset_n,
   output logic             analog_gpio_hiz,
   output logic             digital_gpio_hiz,
   output logic             control_subsys_reset_n,
   output logic             analog_subsys_reset_n,
   output logic             supply_warning_nmi,
   output logic             master_nmi_request,
   output logic             irq,
   // axi4-lite slave
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready
);

   ////////////////////////////////////////////////////////////////////////////////
   // reset combining

   logic        bor_n;        // brown-out result, active low
   logic        ana_req_n;    // analog reset request
   logic        wd_rst_n;     // warning watchdog request, active low
   logic        dig_req_n;    // digital reset request
   logic        dig_int_n;    // internal digital requests, pin excluded
   logic        dig_rst_n;    // released digital reset
   logic        ana_rst_n;    // released analog reset
   smrs_sync_if sync ();      // synchroniser carrier

   // 1v8 monitor gated by the regulator enable pin
   assign bor_n = io_supply_good
                  & ~(~reg_1v8_enable_n & (v1v8_low | v1v8_high));

   // external low on the pin counts as reset
   assign ana_req_n = bor_n & analog_domain_reset_n_i;

   // power-on and/or every request; pin readback left out, added in dig_req_n
   assign dig_int_n = io_supply_good & core_supply_good & aresetn
                      & interrupt_controller_reset_req & wdog0_reset_n
                      & wdog1_reset_n & wd_rst_n;
   // pin readback kept out of oe, or a pulled pin would hold itself low
   assign dig_req_n = dig_int_n & digital_domain_reset_n_i;

   assign sync.req_n = {ana_req_n, dig_req_n};
   assign ana_rst_n  = sync.rel_n[1];
   assign dig_rst_n  = sync.rel_n[0];

   smrs_rst_sync #(.N(2)) u_sync (
      .aclk (aclk),
      .s    (sync)
   );

   // open drain: drive low only, enable while pulling
   assign analog_domain_reset_n_o   = 1'b0;
   assign analog_domain_reset_n_oe  = ~bor_n;
   assign digital_domain_reset_n_o  = 1'b0;
   assign digital_domain_reset_n_oe = ~dig_int_n;

   // domain resets and pin tristate
   assign analog_logic_reset_n = ana_rst_n;
   assign analog_gpio_hiz      = ~ana_rst_n;
   assign digital_gpio_hiz     = ~dig_rst_n;

   ////////////////////////////////////////////////////////////////////////////////
   // registers, all reset by the digital domain reset

   localparam int EV_W = smrs_pkg::EV_W;  // event count, ahead of its first use
   logic [31:0]    ctrl_q;       // warning enable and release bits
   logic [EV_W-1:0] stat_q;      // sticky events
   logic [EV_W-1:0] mask_q;      // interrupt mask
   logic [31:0]    wdload_q;     // watchdog reload value
   logic [31:0]    wdcnt_q;      // watchdog count
   smrs_pkg::smrs_wd_state_t wd_q;  // watchdog state
   logic           warn_d1_q;    // warning edge detect
   logic           ana_d1_q;     // analog reset edge detect
   logic           warn_rise;    // warning start
   logic [EV_W-1:0] ev;          // event pulses
   logic           wr_go;        // write accepted
   logic [31:0]    wr_mask;      // byte lane mask

   // byte enables to bit mask
   function automatic logic [31:0] lanes(input logic [3:0] s);
      return {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
   endfunction

   assign wr_mask = lanes(s_axi_wstrb);

   // monitor only when enabled
   assign warn_rise = ctrl_q[smrs_pkg::CTRL_WARN_EN] & core_supply_warning
                      & ~warn_d1_q;
   assign supply_warning_nmi = ctrl_q[smrs_pkg::CTRL_WARN_EN]
                               & core_supply_warning;
   assign master_nmi_request = warn_rise;

   assign ev[smrs_pkg::EV_WARN]   = warn_rise;
   assign ev[smrs_pkg::EV_WDEXP]  = (wd_q == smrs_pkg::SMRS_WD_FIRE);
   assign ev[smrs_pkg::EV_ABROWN] = ~ana_rst_n & ana_d1_q;

   // edge detect history
   always_ff @(posedge aclk) begin
      if (!dig_rst_n) begin
         warn_d1_q <= 1'b0;
         ana_d1_q  <= 1'b1;
      end else begin
         warn_d1_q <= core_supply_warning;
         ana_d1_q  <= ana_rst_n;
      end
   end

   // control register; whole register cleared by digital reset
   always_ff @(posedge aclk) begin
      if (!dig_rst_n) begin
         ctrl_q <= smrs_pkg::CTRL_RST;
      end else if (wr_go && s_axi_awaddr == smrs_pkg::OFS_CTRL) begin
         ctrl_q <= (ctrl_q & ~wr_mask) | (s_axi_wdata & wr_mask);
      end
   end

   // subsystems wait for their release bits
   assign control_subsys_reset_n = dig_rst_n & ctrl_q[smrs_pkg::CTRL_CTL_REL];
   assign analog_subsys_reset_n  = dig_rst_n & ana_rst_n
                                   & ctrl_q[smrs_pkg::CTRL_ANA_REL];

   // sticky status, set wins over write-one-clear
   always_ff @(posedge aclk) begin
      if (!dig_rst_n) begin
         stat_q <= '0;
      end else if (wr_go && s_axi_awaddr == smrs_pkg::OFS_STATUS && s_axi_wstrb[0]) begin
         stat_q <= (stat_q & ~s_axi_wdata[EV_W-1:0]) | ev;
      end else begin
         stat_q <= stat_q | ev;
      end
   end

   // mask and reload
   always_ff @(posedge aclk) begin
      if (!dig_rst_n) begin
         mask_q   <= smrs_pkg::MASK_RST[EV_W-1:0];
         wdload_q <= smrs_pkg::WDLOAD_RST;
      end else if (wr_go) begin
         if (s_axi_awaddr == smrs_pkg::OFS_MASK && s_axi_wstrb[0]) begin
            mask_q <= s_axi_wdata[EV_W-1:0];
         end
         if (s_axi_awaddr == smrs_pkg::OFS_WDLOAD) begin
            wdload_q <= (wdload_q & ~wr_mask) | (s_axi_wdata & wr_mask);
         end
      end
   end

   assign irq = |(stat_q & mask_q);

   ////////////////////////////////////////////////////////////////////////////////
   // warning watchdog

   // load on warning, count to zero, fire one cycle of reset
   always_ff @(posedge aclk) begin
      if (!dig_rst_n) begin
         wd_q    <= smrs_pkg::SMRS_WD_IDLE;
         wdcnt_q <= '0;
      end else begin
         case (wd_q)
            smrs_pkg::SMRS_WD_IDLE: begin
               if (warn_rise) begin
                  wdcnt_q <= wdload_q;
                  wd_q    <= smrs_pkg::SMRS_WD_RUN;
               end
            end
            smrs_pkg::SMRS_WD_RUN: begin
               if (wdcnt_q == 32'h0000_0000) begin
                  wd_q <= smrs_pkg::SMRS_WD_FIRE;
               end else begin
                  wdcnt_q <= wdcnt_q - 32'h0000_0001;
               end
            end
            smrs_pkg::SMRS_WD_FIRE: begin
               wd_q <= smrs_pkg::SMRS_WD_FIRE;           // held until reset lands
            end
            default: begin
               wd_q <= smrs_pkg::SMRS_WD_IDLE;
            end
         endcase
      end
   end

   assign wd_rst_n = (wd_q != smrs_pkg::SMRS_WD_FIRE);

   ////////////////////////////////////////////////////////////////////////////////
   // axi4-lite slave; bus logic lives with the digital domain

   // both channels taken at one edge: nothing to latch, so the address
   // and data that the write uses are the ones still on the bus
   assign wr_go = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
   assign s_axi_awready = wr_go;
   assign s_axi_wready  = wr_go;

   // write handshake; whichever channel comes first waits for the other
   always_ff @(posedge aclk) begin
      if (!dig_rst_n) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= smrs_pkg::RESP_OKAY;
      end else if (wr_go) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= (s_axi_awaddr > smrs_pkg::OFS_WDCOUNT)
                         ? smrs_pkg::RESP_SLVERR : smrs_pkg::RESP_OKAY;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   assign s_axi_arready = ~s_axi_rvalid;

   // read path
   always_ff @(posedge aclk) begin
      if (!dig_rst_n) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= '0;
         s_axi_rresp  <= smrs_pkg::RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= smrs_pkg::RESP_OKAY;
         case (s_axi_araddr)
            smrs_pkg::OFS_CTRL:    s_axi_rdata <= ctrl_q;
            smrs_pkg::OFS_STATUS:  s_axi_rdata <= {{(32-EV_W){1'b0}}, stat_q};
            smrs_pkg::OFS_MASK:    s_axi_rdata <= {{(32-EV_W){1'b0}}, mask_q};
            smrs_pkg::OFS_LEVEL:   s_axi_rdata <= {28'h0000000, core_supply_warning,
                                                  ana_rst_n, io_supply_good,
                                                  core_supply_good};
            smrs_pkg::OFS_WDLOAD:  s_axi_rdata <= wdload_q;
            smrs_pkg::OFS_WDCOUNT: s_axi_rdata <= wdcnt_q;
            default: begin
               s_axi_rdata <= '0;
               s_axi_rresp <= smrs_pkg::RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // checks

   AST_WD_RESET: assert property (@(posedge aclk) disable iff (!aresetn)
      wd_q == smrs_pkg::SMRS_WD_FIRE |-> ##[1:3] !dig_rst_n)
      else $error("watchdog expiry did not reset digital domain");
   AST_NMI_START: assert property (@(posedge aclk) disable iff (!dig_rst_n)
      master_nmi_request |=> wd_q == smrs_pkg::SMRS_WD_RUN)
      else $error("nmi without watchdog start");
   AST_WARN_OFF: assert property (@(posedge aclk)
      $rose(dig_rst_n) |-> !ctrl_q[smrs_pkg::CTRL_WARN_EN] && !supply_warning_nmi)
      else $error("warning enabled after reset");
   AST_REL_HOLD: assert property (@(posedge aclk)
      !ctrl_q[smrs_pkg::CTRL_CTL_REL] |-> !control_subsys_reset_n)
      else $error("control subsystem released without bit");
   AST_IO_HOLD: assert property (@(posedge aclk)
      !io_supply_good |-> analog_domain_reset_n_oe && digital_domain_reset_n_oe)
      else $error("reset pins not driven while io supply low");
   AST_BOR_GATE: assert property (@(posedge aclk)
      reg_1v8_enable_n && io_supply_good |-> !analog_domain_reset_n_oe)
      else $error("1v8 monitor active with regulator off");
   AST_EXT_LOW: assert property (@(posedge aclk)
      !analog_domain_reset_n_i |=> ##1 analog_gpio_hiz)
      else $error("external analog reset ignored");
   AST_DIG_HIZ: assert property (@(posedge aclk)
      !wdog0_reset_n |-> ##[0:2] digital_gpio_hiz)
      else $error("watchdog request did not reset digital domain");
   AST_ANA_REL: assert property (@(posedge aclk)
      $rose(ana_req_n) |-> !analog_logic_reset_n ##1 !analog_logic_reset_n)
      else $error("analog reset released too early");
endmodule

/* File: include/smrs_pkg.sv */
// smrs_pkg: constants shared by the supply monitor reset sequencer
// assumes: one 250 MHz clock, axi4-lite register access, 32-bit data
package smrs_pkg;
   // register byte offsets
   localparam logic [7:0] OFS_CTRL    = 8'h00;  // warning enable, release bits
   localparam logic [7:0] OFS_STATUS  = 8'h04;  // sticky events, write one to clear
   localparam logic [7:0] OFS_MASK    = 8'h08;  // interrupt mask
   localparam logic [7:0] OFS_LEVEL   = 8'h0C;  // live state, read only
   localparam logic [7:0] OFS_WDLOAD  = 8'h10;  // warning watchdog reload
   localparam logic [7:0] OFS_WDCOUNT = 8'h14;  // warning watchdog count, read only
   // control field positions
   localparam int CTRL_WARN_EN = 0;  // core supply warning enable
   localparam int CTRL_CTL_REL = 1;  // control subsystem release
   localparam int CTRL_ANA_REL = 2;  // analog subsystem release
   // status / mask field positions
   localparam int EV_WARN   = 0;  // core supply warning seen
   localparam int EV_WDEXP  = 1;  // warning watchdog expired
   localparam int EV_ABROWN = 2;  // analog domain reset seen
   localparam int EV_W      = 3;
   // reset values
   localparam logic [31:0] CTRL_RST   = 32'h0000_0000;
   localparam logic [31:0] MASK_RST   = 32'h0000_0000;
   localparam logic [31:0] WDLOAD_RST = 32'h0000_FFFF;
   // axi response codes
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // watchdog states
   typedef enum logic [1:0] {
      SMRS_WD_IDLE = 2'b00,
      SMRS_WD_RUN  = 2'b01,
      SMRS_WD_FIRE = 2'b10
   } smrs_wd_state_t;
endpackage

/* File: include/smrs_sync_if.sv */
// smrs_sync_if: reset requests into and released resets out of the synchroniser
// assumes: both ends clocked by the same aclk
interface smrs_sync_if;
   logic [1:0] req_n;  // raw active low reset requests
   logic [1:0] rel_n;  // released resets, active low
   modport src (output req_n, input rel_n);
   modport dst (input req_n, output rel_n);
endinterface

/* File: src/smrs_rst_sync.sv */
// smrs_rst_sync: assert-now, release-late reset synchronisers
// assumes: aclk free running; req_n may fall at any time
module smrs_rst_sync #(
   parameter int N = 2
) (
   input  wire logic aclk,
   smrs_sync_if.dst  s
);
   genvar i;
   generate
      for (i = 0; i < N; i++) begin : g_sync
         logic st1_q;  // first stage, read only by the second
         logic st2_q;  // second stage drives the output
         // asynchronous assert, two-stage synchronous release
         always_ff @(posedge aclk or negedge s.req_n[i]) begin
            if (!s.req_n[i]) begin
               st1_q <= 1'b0;
               st2_q <= 1'b0;
            end else begin
               st1_q <= 1'b1;
               st2_q <= st1_q;
            end
         end
         assign s.rel_n[i] = st2_q;
      end
   endgenerate
endmodule

/* File: test/smrs_far_side.sv */
// smrs_far_side: board side of the two open-drain reset pins
// assumes: pull-ups on both pins; the bench drives the external hold
module smrs_far_side (
   input  wire logic ana_o,
   input  wire logic ana_oe,
   input  wire logic dig_o,
   input  wire logic dig_oe,
   input  wire logic ext_hold_n,
   output logic      ana_pin,
   output logic      dig_pin
);
   timeunit 1ns;
   timeprecision 1ns;
   ////////////////////////////////////////////////////////////////////////////////
   // wired-and with pull-up: an external low always wins
   assign ana_pin = (ana_oe ? ana_o : 1'b1) & ext_hold_n;
   // digital pin left unheld so only the device pulls it
   assign dig_pin = dig_oe ? dig_o : 1'b1;
endmodule

/* File: test/supply_monitor_reset_sequencer_bench.sv */
// supply_monitor_reset_sequencer_bench: directed tests over axi4-lite and pins
// assumes: smrs_pkg compiled first; pins resolved by smrs_far_side
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_fail++; \
   $display("mismatch %s exp %0h got %0h", nm, e, g); end end
`define WAITF(c) begin k = 0; while (!(c) && k < 400) begin @(posedge aclk); k++; end end
module supply_monitor_reset_sequencer_bench;
   timeunit 1ns;
   timeprecision 1ns;
   ////////////////////////////////////////////////////////////////////////////////
   // stimulus and observed signals, named as the design ports
   logic aclk, aresetn, io_supply_good, core_supply_good, v1v8_low, v1v8_high;
   logic core_supply_warning, reg_1v8_enable_n, interrupt_controller_reset_req;
   logic wdog0_reset_n, wdog1_reset_n, analog_domain_reset_n_i, analog_domain_reset_n_o;
   logic analog_domain_reset_n_oe, digital_domain_reset_n_i, digital_domain_reset_n_o;
   logic digital_domain_reset_n_oe, analog_logic_reset_n, analog_gpio_hiz, digital_gpio_hiz;
   logic control_subsys_reset_n, analog_subsys_reset_n, supply_warning_nmi;
   logic master_nmi_request, irq, ext_hold_n;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
   int          n_fail, cmp_count, cyc, k;
   ////////////////////////////////////////////////////////////////////////////////
   smrs_top dut (.aclk, .aresetn, .io_supply_good, .core_supply_good, .v1v8_low, .v1v8_high,
      .core_supply_warning, .reg_1v8_enable_n, .interrupt_controller_reset_req,
      .wdog0_reset_n, .wdog1_reset_n, .analog_domain_reset_n_i, .analog_domain_reset_n_o,
      .analog_domain_reset_n_oe, .digital_domain_reset_n_i, .digital_domain_reset_n_o,
      .digital_domain_reset_n_oe, .analog_logic_reset_n, .analog_gpio_hiz, .digital_gpio_hiz,
      .control_subsys_reset_n, .analog_subsys_reset_n, .supply_warning_nmi,
      .master_nmi_request, .irq, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready);
   // board side resolves both open-drain pins
   smrs_far_side far (.ana_o(analog_domain_reset_n_o), .ana_oe(analog_domain_reset_n_oe),
      .dig_o(digital_domain_reset_n_o), .dig_oe(digital_domain_reset_n_oe),
      .ext_hold_n(ext_hold_n), .ana_pin(analog_domain_reset_n_i),
      .dig_pin(digital_domain_reset_n_i));
   ////////////////////////////////////////////////////////////////////////////////
   // 250 mhz clock
   initial begin
      aclk = 1'b0;
      forever #2 aclk = ~aclk;
   end
   // hang guard, well above the few hundred cycles the tests need
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_fail++;
         complete_run();
      end
   end
   task automatic tick(input int n);
      repeat (n) @(posedge aclk);
   endtask
   // axi write: address and data offered together, each dropped once taken
   task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      logic aw_ok, w_ok;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      forever begin
         @(posedge aclk);
         if (aw_ok && w_ok && s_axi_bvalid) begin
            r = s_axi_bresp;
            s_axi_bready <= 1'b0;
            break;
         end
         if (!aw_ok && s_axi_awready) begin
            aw_ok = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (!w_ok && s_axi_wready) begin
            w_ok = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end
      @(posedge aclk);  // idle edge so the next call never re-drives bready at once
   endtask
   // axi read: rready held until rvalid is seen
   task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      logic ar_ok;
      ar_ok = 1'b0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      forever begin
         @(posedge aclk);
         if (ar_ok && s_axi_rvalid) begin
            d = s_axi_rdata;
            r = s_axi_rresp;
            s_axi_rready <= 1'b0;
            break;
         end
         if (!ar_ok && s_axi_arready) begin
            ar_ok = 1'b1;
            s_axi_arvalid <= 1'b0;
         end
      end
      @(posedge aclk);  // idle edge so the next call never re-drives rready at once
   endtask
   task automatic complete_run;
      $display("counts: %0d compared, %0d mismatched", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // main sequence: power-up, registers, release, warning, brown-out, requests
   initial begin
      {n_fail, cmp_count, cyc, k} = '0;
      {aresetn, io_supply_good, core_supply_good, v1v8_low, v1v8_high} = '0;
      {core_supply_warning, reg_1v8_enable_n, s_axi_awvalid, s_axi_wvalid} = '0;
      {s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {interrupt_controller_reset_req, wdog0_reset_n, wdog1_reset_n, ext_hold_n} = 4'hF;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      s_axi_wstrb = 4'hF;
      tick(20);
      aresetn <= 1'b1;
      tick(10);
      `CHK("ana_oe", 1'b1, analog_domain_reset_n_oe)
      `CHK("dig_oe", 1'b1, digital_domain_reset_n_oe)
      `CHK("ana_hiz", 1'b1, analog_gpio_hiz)
      `CHK("dig_hiz", 1'b1, digital_gpio_hiz)
      io_supply_good <= 1'b1;
      tick(1);
      `CHK("ana_rst_early", 1'b0, analog_logic_reset_n)
      tick(10);
      `CHK("ana_rst", 1'b1, analog_logic_reset_n)
      `CHK("ana_hiz", 1'b0, analog_gpio_hiz)
      `CHK("dig_oe", 1'b1, digital_domain_reset_n_oe)
      core_supply_good <= 1'b1;
      tick(10);
      `CHK("dig_oe", 1'b0, digital_domain_reset_n_oe)
      `CHK("dig_hiz", 1'b0, digital_gpio_hiz)
      $display("test power_up done");
      axr(smrs_pkg::OFS_CTRL, rd, rs);
      `CHK("ctrl", smrs_pkg::CTRL_RST, rd)
      axr(smrs_pkg::OFS_WDLOAD, rd, rs);
      `CHK("wdload", smrs_pkg::WDLOAD_RST, rd)
      axr(8'h18, rd, rs);
      `CHK("rresp", smrs_pkg::RESP_SLVERR, rs)
      axw(8'h18, 32'h0000_0007, rs);
      `CHK("bresp", smrs_pkg::RESP_SLVERR, rs)
      `CHK("ctl_rst", 1'b0, control_subsys_reset_n)
      axw(smrs_pkg::OFS_CTRL, 32'h0000_0002, rs);
      tick(2);
      `CHK("ctl_rst", 1'b1, control_subsys_reset_n)
      `CHK("ana_sub", 1'b0, analog_subsys_reset_n)
      axw(smrs_pkg::OFS_CTRL, 32'h0000_0006, rs);
      tick(2);
      `CHK("ana_sub", 1'b1, analog_subsys_reset_n)
      $display("test release done");
      // warning while still disabled must stay silent
      core_supply_warning <= 1'b1;
      tick(3);
      `CHK("nmi_off", 1'b0, supply_warning_nmi)
      core_supply_warning <= 1'b0;
      axw(smrs_pkg::OFS_WDLOAD, 32'h0000_0064, rs);
      axw(smrs_pkg::OFS_CTRL, 32'h0000_0007, rs);
      tick(2);
      core_supply_warning <= 1'b1;
      `WAITF(master_nmi_request)
      `CHK("nmi_req", 1'b1, master_nmi_request)
      `CHK("nmi", 1'b1, supply_warning_nmi)
      tick(1);
      `CHK("nmi_req_pulse", 1'b0, master_nmi_request)
      core_supply_warning <= 1'b0;
      axr(smrs_pkg::OFS_STATUS, rd, rs);
      `CHK("stat_warn", 1'b1, rd[smrs_pkg::EV_WARN])
      `CHK("irq_masked", 1'b0, irq)
      axw(smrs_pkg::OFS_MASK, 32'h0000_0001, rs);
      tick(2);
      `CHK("irq", 1'b1, irq)
      axw(smrs_pkg::OFS_STATUS, 32'h0000_0001, rs);
      tick(2);
      `CHK("irq_clr", 1'b0, irq)
      // the countdown of 100 ends in a digital reset
      `WAITF(digital_domain_reset_n_oe)
      `CHK("wd_fire", 1'b1, digital_domain_reset_n_oe)
      tick(2);
      `CHK("ctl_rst_wd", 1'b0, control_subsys_reset_n)
      `WAITF(!digital_domain_reset_n_oe)
      tick(5);
      axr(smrs_pkg::OFS_CTRL, rd, rs);
      `CHK("ctrl_after_wd", smrs_pkg::CTRL_RST, rd)
      $display("test warning done");
      // brown-out table: 1v8 off, 1v8 low, 1v8 high, io low
      for (int i = 0; i < 4; i++) begin
         reg_1v8_enable_n <= (i == 0);
         v1v8_low <= (i < 2);
         v1v8_high <= (i == 2);
         io_supply_good <= (i != 3);
         tick(3);
         `CHK("bor_oe", (i != 0), analog_domain_reset_n_oe)
         {v1v8_low, v1v8_high, io_supply_good} <= 3'h1;
         tick(10);
      end
      ext_hold_n <= 1'b0;
      tick(6);
      `CHK("ext_rst", 1'b0, analog_logic_reset_n)
      `CHK("ext_hiz", 1'b1, analog_gpio_hiz)
      ext_hold_n <= 1'b1;
      tick(10);
      axr(smrs_pkg::OFS_STATUS, rd, rs);
      `CHK("stat_abrown", 1'b1, rd[smrs_pkg::EV_ABROWN])
      $display("test brown_out done");
      // each request alone pulls the digital pin
      for (int i = 0; i < 3; i++) begin
         interrupt_controller_reset_req <= (i != 0);
         wdog0_reset_n <= (i != 1);
         wdog1_reset_n <= (i != 2);
         tick(1);
         `CHK("req_oe", 1'b1, digital_domain_reset_n_oe)
         {interrupt_controller_reset_req, wdog0_reset_n, wdog1_reset_n} <= 3'h7;
         `WAITF(!digital_domain_reset_n_oe)
         `CHK("req_rel", 1'b0, digital_domain_reset_n_oe)
         tick(3);
      end
      $display("test requests done");
      complete_run();
   end
endmodule
